// >>> inc/sfb_pkg.sv
// constants for the sensor buffer and axis standby block
package sfb_pkg;
    localparam logic [6:0] ADDR_BASE = 7'h68;
    localparam logic [6:0] ADDR_STRAP_ONE = 7'h69;
    localparam logic [7:0] OFS_BUF_ENABLE = 8'h23;
    localparam logic [7:0] OFS_CONFIG = 8'h1A;
    localparam logic [7:0] OFS_INT_STATUS = 8'h3A;
    localparam logic [7:0] OFS_SENSOR_FIRST = 8'h3B;
    localparam logic [7:0] OFS_USER_CTRL = 8'h6A;
    localparam logic [7:0] OFS_AXIS_STANDBY = 8'h6C;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h72;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h73;
    localparam logic [7:0] OFS_DATA_PORT = 8'h74;
    localparam logic [7:0] OFS_IDENTITY = 8'h75;
    localparam int SENSOR_REGS = 14;
    localparam int BUF_DEPTH = 512;
    localparam int PTR_W = 9;
    localparam int COUNT_W = 13;
    localparam int BIT_BUF_MODE = 6;
    localparam int BIT_BUF_OP = 6;
    localparam int BIT_BUF_RESET = 2;
    localparam int BIT_OVERFLOW = 4;
    localparam int STANDBY_W = 3;
    localparam int COUNT_HIGH_W = 5;
    localparam logic [7:0] EMPTY_MARK = 8'hFF;
    localparam logic [7:0] CLAMP_VALUE = 8'hFE;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // identity value is arbitrary
    localparam logic [7:0] IDENTITY_VALUE = 8'h5A;
endpackage : sfb_pkg

// >>> rtl/sfb_byte_buffer.sv
// byte buffer with overwrite or hold policy on overflow
`timescale 1ns/100ps
module sfb_byte_buffer
    import sfb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic flush,
    input wire logic holdMode,
    input wire logic pushValid,
    input wire logic [7:0] pushData,
    input wire logic popReq,
    output logic [7:0] headData,
    output logic isEmpty,
    output logic overflow,
    output logic [COUNT_W-1:0] fill
);
    logic [7:0] mem [BUF_DEPTH];
    logic [PTR_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [COUNT_W-1:0] fill_r, fill_nxt;
    logic full, doPush, doPop, dropOld;

    assign full = (fill_r == COUNT_W'(BUF_DEPTH));
    assign isEmpty = (fill_r == '0);
    assign headData = mem[rdPtr_r];
    assign fill = fill_r;
    assign doPop = popReq && !isEmpty;
    // overflow: overwrite oldest unless hold mode
    assign overflow = pushValid && full && !doPop; // RULE_08
    assign doPush = pushValid && !(overflow && holdMode); // RULE_09
    assign dropOld = overflow && !holdMode; // RULE_09

    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        fill_nxt = fill_r;
        if (doPush) begin
            wrPtr_nxt = wrPtr_r + PTR_W'(1);
        end
        if (doPop || dropOld) begin
            rdPtr_nxt = rdPtr_r + PTR_W'(1);
        end
        if (doPush && !doPop && !dropOld) begin
            fill_nxt = fill_r + COUNT_W'(1); // RULE_16
        end else if (doPop && !doPush) begin
            fill_nxt = fill_r - COUNT_W'(1); // RULE_16
        end
    end

    always_ff @(posedge clk) begin
        if (reset || flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            fill_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            fill_r <= fill_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_r] <= pushData;
        end
    end

    fill_bound_a: assert property (@(posedge clk) disable iff (reset) // RULE_16
        fill_r <= COUNT_W'(BUF_DEPTH)) else $error("fill above depth");
    hold_keeps_a: assert property (@(posedge clk) disable iff (reset || flush) // RULE_09
        (overflow && holdMode) |=> $stable(wrPtr_r)) else $error("hold mode overwrote");
endmodule : sfb_byte_buffer

// >>> rtl/sfb_sensor_regs.sv
// register side of the sensor buffer: i2c target, standby, buffer, count, identity
`timescale 1ns/100ps
module sfb_sensor_regs
    import sfb_pkg::*;
// Behaviour
// RULE_01 - bits 2..0 of the standby register put the x, y and z axes in standby, bits 7..3 read zero.
// RULE_02 - the fill count is 13 bits, high five bits in the high byte and low eight in the low byte.
// RULE_03 - reading the high count byte latches the whole count into both count bytes.
// RULE_04 - the host reads the high byte first; a low-byte read alone returns the old latched part.
// RULE_05 - one data port register reads bytes out of the buffer and writes bytes into it.
// RULE_06 - each sample tick pushes the enabled sensor registers in ascending register order.
// RULE_07 - a sensor register is pushed only when its enable flag is set; a host data-port write on its sweep step pushes it anyway.
// RULE_08 - an overflow sets the overflow flag in the interrupt status register by hardware.
// RULE_09 - on overflow the oldest byte is dropped, unless buffer mode bit 6 holds old data.
// RULE_10 - reading the data port of an empty buffer returns 0xFF.
// RULE_11 - valid buffered data is never 0xFF.
// RULE_12 - a read-only register holds a fixed 8-bit identity code.
// RULE_13 - the device answers at i2c address 0x68 or 0x69 chosen by the address select pin.
// RULE_14 - buffer operation bit 6 of user control enables host access to the buffer.
// RULE_15 - writing the buffer reset bit flushes the buffer and the bit clears after one cycle.
// RULE_16 - each pushed byte raises the fill count by one and each popped byte lowers it by one.
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addressSelectPin,
    input wire logic sampleTick,
    input wire logic [8*SENSOR_REGS-1:0] sensorData,
    output logic [STANDBY_W-1:0] axisStandby
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] syncA_r, syncB_r;
    logic sclPrev_r, sdaPrev_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            syncA_r <= 3'h7;
            syncB_r <= 3'h7;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            syncA_r <= {addressSelectPin, sdaIn, sclIn};
            syncB_r <= syncA_r;
            sclPrev_r <= syncB_r[0];
            sdaPrev_r <= syncB_r[1];
        end
    end
    logic scl, sda, sclRise, sclFall, startCond, stopCond;
    assign scl = syncB_r[0];
    assign sda = syncB_r[1];
    assign sclRise = scl && !sclPrev_r;
    assign sclFall = !scl && sclPrev_r;
    assign startCond = scl && sclPrev_r && sdaPrev_r && !sda;
    assign stopCond = scl && sclPrev_r && !sdaPrev_r && sda;

    // ------------------------------------------------------------
    // i2c target state
    // ------------------------------------------------------------
    typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WDATA, ST_WACK,
                  ST_RDATA, ST_RACK} sfb_state_t;
    sfb_state_t state_r, state_nxt;
    logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    logic isRead_r, isRead_nxt, sdaOut_r, sdaOut_nxt, sdaOe_r, sdaOe_nxt;
    logic strap_r;
    logic [6:0] myAddr;
    assign myAddr = strap_r ? ADDR_STRAP_ONE : ADDR_BASE; // RULE_13

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [STANDBY_W-1:0] standby_r, standby_nxt;
    logic [SENSOR_REGS-1:0] bufEnable_r, bufEnable_nxt;
    logic holdMode_r, holdMode_nxt, bufOp_r, bufOp_nxt, flush_r, flush_nxt;
    logic ovfFlag_r, ovfFlag_nxt;
    logic [COUNT_W-1:0] countLatch_r, countLatch_nxt;
    logic [3:0] pushIdx_r, pushIdx_nxt;
    logic pushing_r, pushing_nxt;

    logic wrStrobe, rdStrobe, popReq, pushValid, overflow, bufEmpty;
    logic [7:0] headData, pushByte, rdByte, rawByte;
    logic [COUNT_W-1:0] fill;

    // register write commits at the ack of a data byte, read fetch at byte start
    assign wrStrobe = (state_r == ST_WDATA) && sclFall && (bitCnt_r == 4'h8);
    assign rdStrobe = (state_r != ST_RDATA) && (state_nxt == ST_RDATA);
    assign popReq = rdStrobe && (ptr_r == OFS_DATA_PORT) && bufOp_r; // RULE_14

    // sensor pushes follow the tick in ascending order, skipping disabled ones unless a host data-port write lands on that step
    assign rawByte = sensorData[8*pushIdx_r +: 8];
    assign pushByte = (rawByte == EMPTY_MARK) ? CLAMP_VALUE : rawByte; // RULE_11
    assign pushValid = (pushing_r && bufEnable_r[pushIdx_r]) // RULE_06 RULE_07
        || (wrStrobe && ptr_r == OFS_DATA_PORT && bufOp_r && shift_r != EMPTY_MARK); // RULE_05

    sfb_byte_buffer u_buffer (
        .clk(clk),
        .reset(reset),
        .flush(flush_r), // RULE_15
        .holdMode(holdMode_r),
        .pushValid(pushValid),
        .pushData(pushing_r ? pushByte : shift_r),
        .popReq(popReq),
        .headData(headData),
        .isEmpty(bufEmpty),
        .overflow(overflow),
        .fill(fill)
    );

    always_comb begin
        unique case (ptr_r)
            OFS_AXIS_STANDBY: rdByte = {5'h00, standby_r}; // RULE_01
            OFS_COUNT_HIGH: rdByte = {3'h0, fill[COUNT_W-1 -: COUNT_HIGH_W]}; // RULE_02
            OFS_COUNT_LOW: rdByte = countLatch_r[7:0]; // RULE_04
            OFS_DATA_PORT: rdByte = (bufEmpty || !bufOp_r) ? EMPTY_MARK : headData; // RULE_10
            OFS_IDENTITY: rdByte = IDENTITY_VALUE; // RULE_12
            OFS_BUF_ENABLE: rdByte = bufEnable_r[7:0];
            OFS_CONFIG: rdByte = {1'b0, holdMode_r, 6'h00};
            OFS_USER_CTRL: rdByte = {1'b0, bufOp_r, 6'h00};
            OFS_INT_STATUS: rdByte = {3'h0, ovfFlag_r, 4'h0};
            default: rdByte = ZERO_BYTE;
        endcase
    end

    always_comb begin
        standby_nxt = standby_r;
        bufEnable_nxt = bufEnable_r;
        holdMode_nxt = holdMode_r;
        bufOp_nxt = bufOp_r;
        flush_nxt = 1'b0; // RULE_15
        countLatch_nxt = countLatch_r;
        pushing_nxt = pushing_r;
        pushIdx_nxt = pushIdx_r;
        ovfFlag_nxt = ovfFlag_r;
        if (rdStrobe && ptr_r == OFS_INT_STATUS) begin
            ovfFlag_nxt = 1'b0;
        end
        if (overflow) begin
            ovfFlag_nxt = 1'b1; // RULE_08
        end
        if (rdStrobe && ptr_r == OFS_COUNT_HIGH) begin
            countLatch_nxt = fill; // RULE_03
        end
        if (wrStrobe) begin
            unique case (ptr_r)
                OFS_AXIS_STANDBY: standby_nxt = shift_r[STANDBY_W-1:0]; // RULE_01
                OFS_BUF_ENABLE: bufEnable_nxt = {6'h00, shift_r};
                OFS_CONFIG: holdMode_nxt = shift_r[BIT_BUF_MODE];
                OFS_USER_CTRL: begin
                    bufOp_nxt = shift_r[BIT_BUF_OP]; // RULE_14
                    flush_nxt = shift_r[BIT_BUF_RESET]; // RULE_15
                end
                default: ;
            endcase
        end
        if (pushing_r) begin
            pushIdx_nxt = pushIdx_r + 4'h1;
            if (pushIdx_r == 4'(SENSOR_REGS - 1)) begin
                pushing_nxt = 1'b0;
            end
        end else if (sampleTick) begin
            pushing_nxt = 1'b1; // RULE_06
            pushIdx_nxt = 4'h0;
        end
    end

    // ------------------------------------------------------------
    // i2c target next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        bitCnt_nxt = bitCnt_r;
        isRead_nxt = isRead_r;
        sdaOut_nxt = sdaOut_r;
        sdaOe_nxt = sdaOe_r;
        if (stopCond) begin
            state_nxt = ST_IDLE;
            sdaOe_nxt = 1'b0;
        end else if (startCond) begin
            state_nxt = ST_ADDR;
            bitCnt_nxt = 4'h0;
            sdaOe_nxt = 1'b0;
        end else if (sclRise && bitCnt_r < 4'h8 && state_r != ST_IDLE
                && state_r != ST_RDATA) begin
            shift_nxt = {shift_r[6:0], sda};
            bitCnt_nxt = bitCnt_r + 4'h1;
        end else if (sclRise && state_r == ST_RACK) begin
            // not-acknowledge ends the read, acknowledge waits for the fall
            if (sda) begin
                state_nxt = ST_IDLE;
            end else if (ptr_r != OFS_DATA_PORT) begin
                ptr_nxt = ptr_r + 8'h01;
            end
        end else if (sclFall) begin
            unique case (state_r)
                ST_ADDR: if (bitCnt_r == 4'h8) begin
                    if (shift_r[7:1] == myAddr) begin // RULE_13
                        isRead_nxt = shift_r[0];
                        state_nxt = ST_ADDR_ACK;
                        sdaOut_nxt = 1'b0;
                        sdaOe_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WACK: begin
                    bitCnt_nxt = 4'h0;
                    sdaOe_nxt = 1'b0;
                    if (state_r == ST_ADDR_ACK && isRead_r) begin
                        state_nxt = ST_RDATA;
                    end else if (state_r == ST_ADDR_ACK) begin
                        state_nxt = ST_PTR;
                    end else begin
                        state_nxt = ST_WDATA;
                    end
                end
                ST_PTR, ST_WDATA: if (bitCnt_r == 4'h8) begin
                    if (state_r == ST_PTR) begin
                        ptr_nxt = shift_r;
                        state_nxt = ST_PTR_ACK;
                    end else begin
                        state_nxt = ST_WACK;
                        if (ptr_r != OFS_DATA_PORT) begin
                            ptr_nxt = ptr_r + 8'h01;
                        end
                    end
                    sdaOut_nxt = 1'b0;
                    sdaOe_nxt = 1'b1;
                end
                ST_RDATA: if (bitCnt_r == 4'h8) begin
                    state_nxt = ST_RACK;
                    sdaOe_nxt = 1'b0;
                end else begin
                    sdaOut_nxt = shift_r[7];
                    sdaOe_nxt = !shift_r[7];
                    shift_nxt = {shift_r[6:0], 1'b1};
                    bitCnt_nxt = bitCnt_r + 4'h1;
                end
                ST_RACK: state_nxt = ST_RDATA;
                default: ;
            endcase
        end
        // first read bit goes out on the fall that enters the data phase
        if (rdStrobe) begin
            shift_nxt = {rdByte[6:0], 1'b1};
            bitCnt_nxt = 4'h1;
            sdaOut_nxt = rdByte[7];
            sdaOe_nxt = !rdByte[7];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            bitCnt_r <= 4'h0;
            isRead_r <= 1'b0;
            sdaOut_r <= 1'b1;
            sdaOe_r <= 1'b0;
            standby_r <= '0;
            bufEnable_r <= '0;
            holdMode_r <= 1'b0;
            bufOp_r <= 1'b0;
            flush_r <= 1'b0;
            ovfFlag_r <= 1'b0;
            countLatch_r <= '0;
            pushIdx_r <= 4'h0;
            pushing_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            bitCnt_r <= bitCnt_nxt;
            isRead_r <= isRead_nxt;
            sdaOut_r <= sdaOut_nxt;
            sdaOe_r <= sdaOe_nxt;
            standby_r <= standby_nxt;
            bufEnable_r <= bufEnable_nxt;
            holdMode_r <= holdMode_nxt;
            bufOp_r <= bufOp_nxt;
            flush_r <= flush_nxt;
            ovfFlag_r <= ovfFlag_nxt;
            countLatch_r <= countLatch_nxt;
            pushIdx_r <= pushIdx_nxt;
            pushing_r <= pushing_nxt;
        end
    end

    // strap resampled on every cycle that the target is idle
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            strap_r <= syncB_r[2];
        end
    end

    assign sdaOut = sdaOut_r;
    assign sdaOe = sdaOe_r;
    assign axisStandby = standby_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    flush_self_a: assert property (@(posedge clk) disable iff (reset) // RULE_15
        flush_r |=> !flush_r) else $error("flush bit did not clear");
    ovf_flag_a: assert property (@(posedge clk) disable iff (reset) // RULE_08
        overflow |=> ovfFlag_r) else $error("overflow flag not set");
    empty_mark_a: assert property (@(posedge clk) disable iff (reset) // RULE_10
        (rdStrobe && ptr_r == OFS_DATA_PORT && bufEmpty) |=> shift_r == EMPTY_MARK)
        else $error("empty read not 0xFF");
    no_ff_push_a: assert property (@(posedge clk) disable iff (reset) // RULE_11
        pushValid |-> (pushing_r ? pushByte : shift_r) != EMPTY_MARK)
        else $error("0xFF pushed");
    count_latch_a: assert property (@(posedge clk) disable iff (reset) // RULE_03
        (rdStrobe && ptr_r == OFS_COUNT_HIGH) |=> countLatch_r == $past(fill))
        else $error("count not latched");
    enable_gate_a: assert property (@(posedge clk) disable iff (reset) // RULE_07
        (pushing_r && !bufEnable_r[pushIdx_r] && !wrStrobe) |-> !pushValid)
        else $error("disabled register pushed");
    sweep_start_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
        $rose(pushing_r) |-> pushIdx_r == 4'h0) else $error("sweep start wrong");
    // the sweep index is the counter: one step a cycle, ends after the last register
    sweep_len_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
        pushing_r |=> (pushIdx_r == $past(pushIdx_r) + 4'h1)
            && (pushing_r == ($past(pushIdx_r) != 4'(SENSOR_REGS - 1))))
        else $error("sweep length wrong");
    standby_wr_a: assert property (@(posedge clk) disable iff (reset) // RULE_01
        (wrStrobe && ptr_r == OFS_AXIS_STANDBY) |=> standby_r == $past(shift_r[2:0]))
        else $error("standby not written");
    access_gate_a: assert property (@(posedge clk) disable iff (reset) // RULE_14
        !bufOp_r |-> !popReq) else $error("pop while disabled");
endmodule : sfb_sensor_regs

// >>> bench/sfb_i2c_host.sv
// i2c controller model standing in for the host processor
`timescale 1ns/100ps
module sfb_i2c_host (
    input wire logic clk,
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaLow
);
    // clock idles high between frames, data released to the pull-up
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic hold4();
        repeat (4) @(posedge clk);
    endtask : hold4

    // data moves one cycle after the clock fall, never on the same edge
    task automatic bitOut(input logic b);
        @(posedge clk);
        sdaLow <= !b;
        repeat (3) @(posedge clk);
        sclOut <= 1'b1;
        hold4();
        sclOut <= 1'b0;
    endtask : bitOut

    task automatic bitIn(output logic b);
        @(posedge clk);
        sdaLow <= 1'b0;
        repeat (3) @(posedge clk);
        sclOut <= 1'b1;
        repeat (2) @(posedge clk);
        b = sdaLine;
        repeat (2) @(posedge clk);
        sclOut <= 1'b0;
    endtask : bitIn

    task automatic startCond();
        @(posedge clk);
        sdaLow <= 1'b0;
        hold4();
        sclOut <= 1'b1;
        hold4();
        sdaLow <= 1'b1;
        hold4();
        sclOut <= 1'b0;
    endtask : startCond

    task automatic stopCond();
        @(posedge clk);
        sdaLow <= 1'b1;
        hold4();
        sclOut <= 1'b1;
        hold4();
        sdaLow <= 1'b0;
        hold4();
    endtask : stopCond

    task automatic byteOut(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitOut(d[i]);
        bitIn(a);
        ack = !a;
    endtask : byteOut

    // single byte read, closed by a not-acknowledge
    task automatic byteIn(output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitIn(b);
            d[i] = b;
        end
        bitOut(1'b1);
    endtask : byteIn

    task automatic writeReg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
        output logic ok);
        logic k0, k1, k2;
        startCond();
        byteOut({a, 1'b0}, k0);
        byteOut(p, k1);
        byteOut(v, k2);
        stopCond();
        ok = k0 & k1 & k2;
    endtask : writeReg

    task automatic readReg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
        output logic ok);
        logic k0, k1, k2;
        startCond();
        byteOut({a, 1'b0}, k0);
        byteOut(p, k1);
        startCond();
        byteOut({a, 1'b1}, k2);
        byteIn(d);
        stopCond();
        ok = k0 & k1 & k2;
    endtask : readReg
endmodule : sfb_i2c_host

// >>> bench/sensor_fifo_and_axis_standby_tb.sv
// self-checking bench for the sensor buffer register block
`timescale 1ns/100ps
module sensor_fifo_and_axis_standby_tb import sfb_pkg::*;;
    logic clk, reset, addressSelectPin, sampleTick, sclLine, hostSdaLow, devSdaOut, devSdaOe;
    logic [8*SENSOR_REGS-1:0] sensorData;
    logic [STANDBY_W-1:0] axisStandby;
    logic [6:0] devAddr;
    wire sdaLine;
    int failures = 0;
    int totalChecks = 0;

    // open-drain bus with pull-up
    assign sdaLine = !(hostSdaLow || (devSdaOe && !devSdaOut));

    sfb_sensor_regs uut (.clk(clk), .reset(reset), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(devSdaOut), .sdaOe(devSdaOe), .addressSelectPin(addressSelectPin),
        .sampleTick(sampleTick), .sensorData(sensorData), .axisStandby(axisStandby));
    sfb_i2c_host host (.clk(clk), .sdaLine(sdaLine), .sclOut(sclLine), .sdaLow(hostSdaLow));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask : check

    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        logic ok;
        host.writeReg(devAddr, p, v, ok);
        check("write ack", 16'h0001, {15'h0000, ok});
    endtask : wr

    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic ok;
        host.readReg(devAddr, p, d, ok);
        check("read ack", 16'h0001, {15'h0000, ok});
    endtask : rd

    task automatic expectReg(input string name, input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] d;
        rd(p, d);
        check(name, {8'h00, exp}, {8'h00, d});
    endtask : expectReg

    task automatic expectCount(input logic [12:0] exp);
        logic [7:0] h, l;
        rd(OFS_COUNT_HIGH, h);
        rd(OFS_COUNT_LOW, l);
        check("count", {3'h0, exp}, {h[7:5], h[4:0], l});
    endtask : expectCount

    task automatic tick(input logic [8*SENSOR_REGS-1:0] v);
        @(posedge clk);
        sensorData <= v;
        sampleTick <= 1'b1;
        @(posedge clk);
        sampleTick <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : tick

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_identity();
        logic [7:0] d;
        logic ok;
        expectReg("identity", OFS_IDENTITY, IDENTITY_VALUE);
        wr(OFS_IDENTITY, 8'h00);
        expectReg("identity ro", OFS_IDENTITY, IDENTITY_VALUE);
        host.readReg(7'h69, OFS_IDENTITY, d, ok);
        check("ack 69 strap0", 16'h0000, {15'h0000, ok});
        @(posedge clk) addressSelectPin <= 1'b1;
        repeat (4) @(posedge clk);
        devAddr = 7'h69;
        expectReg("identity 69", OFS_IDENTITY, IDENTITY_VALUE);
        host.readReg(7'h68, OFS_IDENTITY, d, ok);
        check("ack 68 strap1", 16'h0000, {15'h0000, ok});
        @(posedge clk) addressSelectPin <= 1'b0;
        repeat (4) @(posedge clk);
        devAddr = 7'h68;
        $display("test_identity done");
    endtask : test_identity

    task automatic test_standby();
        check("standby reset", 16'h0000, {13'h0000, axisStandby});
        wr(OFS_AXIS_STANDBY, 8'hFD);
        repeat (4) @(posedge clk);
        check("standby x z", 16'h0005, {13'h0000, axisStandby});
        expectReg("standby read", OFS_AXIS_STANDBY, 8'h05);
        wr(OFS_AXIS_STANDBY, 8'h02);
        repeat (4) @(posedge clk);
        check("standby y", 16'h0002, {13'h0000, axisStandby});
        $display("test_standby done");
    endtask : test_standby

    task automatic test_gate_empty();
        wr(OFS_DATA_PORT, 8'h21);
        wr(OFS_USER_CTRL, 8'h40);
        expectCount(13'h0000);
        expectReg("empty port", OFS_DATA_PORT, EMPTY_MARK);
        $display("test_gate_empty done");
    endtask : test_gate_empty

    task automatic test_capture();
        wr(OFS_BUF_ENABLE, 8'h0B);
        tick({{10{8'h5A}}, 32'h443322FF});
        expectCount(13'h0003);
        expectReg("first byte", OFS_DATA_PORT, CLAMP_VALUE);
        expectReg("second byte", OFS_DATA_PORT, 8'h22);
        expectReg("third byte", OFS_DATA_PORT, 8'h44);
        expectReg("drained", OFS_DATA_PORT, EMPTY_MARK);
        expectCount(13'h0000);
        $display("test_capture done");
    endtask : test_capture

    task automatic test_latch();
        wr(OFS_DATA_PORT, 8'h12);
        wr(OFS_DATA_PORT, 8'hFF);
        wr(OFS_DATA_PORT, 8'h34);
        expectReg("latched high", OFS_COUNT_HIGH, 8'h00);
        wr(OFS_DATA_PORT, 8'h56);
        expectReg("latched low", OFS_COUNT_LOW, 8'h02);
        expectCount(13'h0003);
        expectReg("host byte a", OFS_DATA_PORT, 8'h12);
        expectReg("host byte b", OFS_DATA_PORT, 8'h34);
        expectReg("host byte c", OFS_DATA_PORT, 8'h56);
        $display("test_latch done");
    endtask : test_latch

    task automatic test_overflow();
        logic [7:0] d;
        wr(OFS_BUF_ENABLE, 8'hFF);
        for (int t = 0; t < 64; t++) tick({14{t[7:0]}});
        expectCount(13'h0200);
        rd(OFS_INT_STATUS, d);
        check("no overflow yet", 16'h0000, {8'h00, d & 8'h10});
        tick({14{8'h40}});
        rd(OFS_INT_STATUS, d);
        check("overflow flag", 16'h0010, {8'h00, d & 8'h10});
        expectCount(13'h0200);
        expectReg("oldest dropped", OFS_DATA_PORT, 8'h01);
        wr(OFS_CONFIG, 8'h40);
        tick({14{8'h41}});
        rd(OFS_INT_STATUS, d);
        check("overflow hold", 16'h0010, {8'h00, d & 8'h10});
        expectCount(13'h0200);
        expectReg("old kept", OFS_DATA_PORT, 8'h01);
        wr(OFS_USER_CTRL, 8'h44);
        repeat (4) @(posedge clk);
        expectReg("reset self clear", OFS_USER_CTRL, 8'h40);
        expectCount(13'h0000);
        expectReg("empty after reset", OFS_DATA_PORT, EMPTY_MARK);
        $display("test_overflow done");
    endtask : test_overflow

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        addressSelectPin = 1'b0;
        sampleTick = 1'b0;
        sensorData = '0;
        devAddr = 7'h68;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        test_identity();
        test_standby();
        test_gate_empty();
        test_capture();
        test_latch();
        test_overflow();
        final_report();
    end

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : sensor_fifo_and_axis_standby_tb
